// *** shared/touch_ctrl_pkg.sv ***
// Constants for the touch-screen converter control block.
// Assumes a 40 MHz APB clock and 16-bit registers in 32-bit words.
`default_nettype none
package touch_ctrl_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONV_CTRL = 8'h01;
    localparam logic [7:0] IDX_PWR_CTRL = 8'h02;
    localparam logic [7:0] IDX_SEQ_CTRL = 8'h03;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h11;
    localparam logic [7:0] IDX_STATE = 8'h12;
    // Reset values
    localparam logic [15:0] CONV_CTRL_RST = 16'h0000;
    localparam logic [15:0] PWR_CTRL_RST = 16'h4040;
    localparam logic [15:0] SEQ_CTRL_RST = 16'h0000;
    // Field positions
    localparam int PEN_DIS_BIT = 15;
    localparam int CHAN_LSB = 12;
    localparam int MODE_LSB = 10;
    localparam int PM_LSB = 14;
    localparam int SE_BIT = 9;
    localparam int FCD_LSB = 0;
    // Mode and power codes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_SEQ_SLAVE = 2'h2;
    localparam logic [1:0] MODE_SEQ_MASTER = 2'h3;
    localparam logic [1:0] PM_SHUTDOWN = 2'h0;
    localparam logic [1:0] PM_ALWAYS_ON = 2'h2;
    // Channel codes
    localparam logic [2:0] CH_Y_POS = 3'h7;
    localparam logic [2:0] CH_X_POS = 3'h6;
    localparam logic [2:0] CH_PRESS1 = 3'h5;
    localparam logic [2:0] CH_PRESS2 = 3'h4;
    localparam logic [2:0] CH_TEMP = 3'h1;
    localparam logic [2:0] CH_INVALID = 3'h0;
    // Interrupt status bits
    localparam int EV_SEQ_DONE = 0;
    localparam int EV_TOUCH = 1;
    localparam int EV_BAD_CHAN = 2;
    // Delay step and its length in cycles
    localparam int CLK_MHZ = 40;
    localparam int FCD_STEP_US = 128;
    localparam int FCD_STEP_CYCLES = FCD_STEP_US * CLK_MHZ;
endpackage
`default_nettype wire

// *** tb/adc_core_model.sv ***
// ADC core stand-in: one done pulse per conversion start.
// Assumes start is a one-cycle pulse; latency alternates short and long.
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic conv_start,
    output logic conv_done
);
    logic [3:0] cnt;
    logic slow;
    // Both prompt and slow answers, so no fixed latency is assumed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 4'h0;
            slow <= 1'b0;
            conv_done <= 1'b0;
        end
        else
        begin
            conv_done <= (cnt == 4'h1);
            if (conv_start)
            begin
                cnt <= slow ? 4'h9 : 4'h2;
                slow <= !slow;
            end
            else if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
        end
    end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the touch converter control block.
// Assumes package, design and ADC core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk, presetn, psel, penable, pwrite, touch_sense, limit_viol;
    logic pready, pslverr, conv_done, conv_start, conv_single_ended, err;
    logic xp_on, xn_on, yp_on, yn_on, adc_pwr, osc_pwr, bias_pwr, temp_pwr;
    logic pen_touch_irq_n, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] conv_channel;
    int mismatches = 0, samples_checked = 0, cycles = 0, waited;
    // Rows: power word, control word, {channel, xp, xn, yp, yn, single}
    logic [15:0] cpwr [8] = '{16'h4040, 16'h4040, 16'h4240, 16'h4040,
        16'h4040, 16'h4040, 16'h4040, 16'h4240};
    logic [15:0] cval [8] = '{16'h5400, 16'h4400, 16'h5400, 16'h3400,
        16'h1400, 16'h7400, 16'h6400, 16'h7400};
    logic [7:0] cexp [8] = '{8'hac, 8'h8c, 8'ha1, 8'h60, 8'h20, 8'he6,
        8'hd8, 8'he7};
    touch_adc_channel_power_ctrl #(.STEP_CYCLES(4)) dut (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .touch_sense, .limit_viol, .conv_done, .conv_start, .conv_channel,
        .conv_single_ended, .xp_on, .xn_on, .yp_on, .yn_on, .adc_pwr,
        .osc_pwr, .bias_pwr, .temp_pwr, .pen_touch_irq_n, .irq);
    adc_core_model core (.pclk, .presetn, .conv_start, .conv_done);
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = !pclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("mismatches %0d samples_checked %0d", mismatches,
            samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Ceiling well above the thousand or so cycles the tests need
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            mismatches++;
            complete_run;
        end
    end
    task automatic apb(input logic wr, input logic [7:0] idx,
        input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_start(input logic [2:0] ch);
        waited = 0;
        @(negedge pclk);
        while (conv_start !== 1'b1)
        begin
            @(negedge pclk);
            waited++;
        end
        check(conv_channel, ch);
    endtask
    task automatic wait_irq(input logic [15:0] st);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400)
        begin
            @(negedge pclk);
            n++;
        end
        apb(1'b0, 8'h10, 16'h0000);
        check(rd, st);
        apb(1'b1, 8'h10, st);
        repeat (2) @(negedge pclk);
        check(irq, 1'b0);
    endtask
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        touch_sense = 1'b0;
        limit_viol = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, 8'h11, 16'h0007);
        foreach (cval[i])
        begin
            apb(1'b1, 8'h02, cpwr[i]);
            apb(1'b1, 8'h01, cval[i]);
            wait_start(cexp[i][7:5]);
            check({conv_channel, xp_on, xn_on, yp_on, yn_on,
                conv_single_ended}, cexp[i]);
            check(adc_pwr, 1'b1);
            wait_irq(16'h0001);
            apb(1'b0, 8'h01, 16'h0000);
            check(rd, {16'h0000, cval[i] & 16'hf3ff});
        end
        $display("conversion rows done");
        apb(1'b0, 8'h05, 16'h0000);
        check(err, 1'b1);
        apb(1'b1, 8'h03, 16'h00ff);
        apb(1'b0, 8'h03, 16'h0000);
        check(rd, 32'h00fe);
        apb(1'b1, 8'h01, 16'h0400);
        wait_irq(16'h0004);
        apb(1'b1, 8'h03, 16'h00d2);
        apb(1'b1, 8'h01, 16'h0800);
        wait_start(3'h7);
        wait_start(3'h6);
        wait_start(3'h4);
        wait_start(3'h1);
        check(temp_pwr, 1'b1);
        wait_irq(16'h0001);
        apb(1'b1, 8'h03, 16'h0002);
        apb(1'b1, 8'h01, 16'h0c00);
        repeat (2) @(negedge pclk);
        check({adc_pwr, osc_pwr, bias_pwr, temp_pwr}, 4'h0);
        @(posedge pclk);
        touch_sense <= 1'b1;
        wait_start(3'h1);
        repeat (40) @(negedge pclk);
        apb(1'b0, 8'h10, 16'h0000);
        check(rd, 32'h0003);
        apb(1'b1, 8'h10, 16'h0003);
        apb(1'b0, 8'h01, 16'h0000);
        check(rd, 32'h0c00);
        touch_sense <= 1'b0;
        apb(1'b1, 8'h01, 16'h0000);
        $display("sequence done");
        apb(1'b1, 8'h02, 16'h404a);
        apb(1'b1, 8'h01, 16'h5400);
        wait_start(3'h5);
        check(waited >= 45 && waited <= 54, 1'b1);
        wait_irq(16'h0001);
        apb(1'b1, 8'h02, 16'h8040);
        repeat (3) @(negedge pclk);
        check({adc_pwr, osc_pwr, bias_pwr}, 3'h7);
        apb(1'b1, 8'h02, 16'h0040);
        apb(1'b1, 8'h01, 16'h5400);
        repeat (60) @(negedge pclk);
        check({adc_pwr, osc_pwr, bias_pwr, temp_pwr, irq}, 5'h00);
        apb(1'b1, 8'h01, 16'h0000);
        apb(1'b1, 8'h02, 16'h4040);
        @(posedge pclk);
        touch_sense <= 1'b1;
        repeat (6) @(negedge pclk);
        check({pen_touch_irq_n, irq}, 2'h1);
        apb(1'b1, 8'h11, 16'h0000);
        repeat (2) @(negedge pclk);
        check(irq, 1'b0);
        touch_sense <= 1'b0;
        apb(1'b1, 8'h01, 16'h8000);
        limit_viol <= 1'b1;
        repeat (4) @(negedge pclk);
        check(pen_touch_irq_n, 1'b0);
        $display("power and pin done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h02, 16'h0000);
        check(rd, 32'h4040);
        apb(1'b0, 8'h03, 16'h0000);
        check(rd, 32'h0000);
        $display("reset done");
        complete_run;
    end
endmodule
`default_nettype wire

// *** verilog/conv_delay_timer.sv ***
// Counts out the programmed first-conversion delay.
// Assumes start is a one-cycle pulse on the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module conv_delay_timer #(
    parameter int STEP_CYCLES = touch_ctrl_pkg::FCD_STEP_CYCLES
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [3:0] code,
    output logic done
);
    logic [19:0] count;
    logic busy;

    // Steps of 128 us; upper codes jump to coarser values
    function automatic logic [5:0] steps(input logic [3:0] c);
        case (c)
            4'ha: steps = 6'd12;
            4'hb: steps = 6'd14;
            4'hc: steps = 6'd16;
            4'hd: steps = 6'd20;
            4'he: steps = 6'd28;
            4'hf: steps = 6'd32;
            default: steps = 6'({2'h0, c} + 6'd1);
        endcase
    endfunction

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= 20'h00000;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                count <= 20'(steps(code) * STEP_CYCLES - 1);
                busy <= 1'b1;
            end
            else if (busy)
            begin
                if (count == 20'h00000)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                else
                    count <= count - 20'h00001;
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/touch_adc_channel_power_ctrl.sv ***
// Channel, sequence, switch, power and interrupt-pin control.
// Assumes an APB master on pclk and an ADC core answering conv_start
// with a one-cycle conv_done; touch_sense arrives asynchronously.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Single conversion uses channel select field
// - Sequence converts only selected channel bits
// - Bit 9 picks single-ended or ratiometric
// - Pen bit picks touch or limit pin
// - Channel codes decode; code 000 invalid
// - Ratiometric pressure drives X-minus, Y-plus; Y position drives Y-plus/Y-minus, X position X-plus/X-minus; single-ended pressure and others off
// - Power register at 0x02, resets 0x4040
// - Four-bit code sets first-conversion delay
// - Delay before X/Y and after sequence
// - Code 00 shuts everything, overrides mode
// - Code 10 keeps ADC, bias, oscillator on
// - Sequence register layout, bit 0 unused
// - Mode bits select off/single/slave/master
module touch_adc_channel_power_ctrl #(
    parameter int STEP_CYCLES = touch_ctrl_pkg::FCD_STEP_CYCLES
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic touch_sense,
    input wire logic limit_viol,
    input wire logic conv_done,
    output logic conv_start,
    output logic [2:0] conv_channel,
    output logic conv_single_ended,
    output logic xp_on,
    output logic xn_on,
    output logic yp_on,
    output logic yn_on,
    output logic adc_pwr,
    output logic osc_pwr,
    output logic bias_pwr,
    output logic temp_pwr,
    output logic pen_touch_irq_n,
    output logic irq
);
    typedef enum {S_IDLE, S_ARM, S_DELAY, S_LAUNCH, S_CONV, S_POST} state_t;

    state_t state;
    logic [15:0] conv_ctrl;
    logic [15:0] power_filter_delay_control;
    logic [15:0] irq_and_sequence_control;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [2:0] cur;
    logic touch_meta;
    logic touch_sync;
    logic touch_prev;
    logic dly_go;
    logic dly_done;
    logic revert_mode;
    logic [2:0] events;
    logic wr_en;
    logic rd_en;
    logic [9:0] idx;
    logic mapped;
    logic [15:0] rd_word;
    logic [1:0] mode;
    logic [1:0] power_mgmt_field;
    logic [2:0] channel_select;
    logic single_ended_select;
    logic [2:0] first_ch;
    logic [2:0] next_ch;
    logic busy;

    default clocking ast_clk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    assign mode = conv_ctrl[touch_ctrl_pkg::MODE_LSB +: 2];
    assign channel_select = conv_ctrl[touch_ctrl_pkg::CHAN_LSB +: 3];
    assign power_mgmt_field =
        power_filter_delay_control[touch_ctrl_pkg::PM_LSB +: 2];
    assign single_ended_select =
        power_filter_delay_control[touch_ctrl_pkg::SE_BIT];
    assign busy = (state != S_IDLE) && (state != S_ARM);

    // Highest selected channel at or below a start code; 0 when none
    function automatic logic [2:0] pick(input logic [7:0] m,
                                        input logic [2:0] from);
        logic [2:0] r;
        r = touch_ctrl_pkg::CH_INVALID;
        for (int i = 1; i < 8; i++)
        begin
            if (m[i] && (3'(i) <= from))
                r = 3'(i);
        end
        return r;
    endfunction

    // Position channels need a settling delay
    function automatic logic needs_delay(input logic [2:0] c);
        return (c == touch_ctrl_pkg::CH_Y_POS) ||
               (c == touch_ctrl_pkg::CH_X_POS);
    endfunction

    assign first_ch = pick(irq_and_sequence_control[7:0], 3'h7);
    assign next_ch = (cur == 3'h0) ? 3'h0 :
        pick(irq_and_sequence_control[7:0], cur - 3'h1);

    // Touch pin crosses into pclk; only the second and third (edge) stages are read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            touch_meta <= 1'b0;
            touch_sync <= 1'b0;
            touch_prev <= 1'b0;
        end
        else
        begin
            touch_meta <= touch_sense;
            touch_sync <= touch_meta;
            touch_prev <= touch_sync;
        end
    end

    // APB decode; one wait state so read data comes from a flop
    assign idx = paddr[11:2];
    assign mapped = (idx == 10'(touch_ctrl_pkg::IDX_CONV_CTRL)) ||
                    (idx == 10'(touch_ctrl_pkg::IDX_PWR_CTRL)) ||
                    (idx == 10'(touch_ctrl_pkg::IDX_SEQ_CTRL)) ||
                    (idx == 10'(touch_ctrl_pkg::IDX_IRQ_STATUS)) ||
                    (idx == 10'(touch_ctrl_pkg::IDX_IRQ_MASK)) ||
                    (idx == 10'(touch_ctrl_pkg::IDX_STATE));
    assign wr_en = psel && penable && pready && pwrite && mapped;
    assign rd_en = psel && penable && !pready;

    always_comb
    begin
        rd_word = 16'h0000;
        case (idx)
            10'(touch_ctrl_pkg::IDX_CONV_CTRL): rd_word = conv_ctrl;
            10'(touch_ctrl_pkg::IDX_PWR_CTRL):
                rd_word = power_filter_delay_control;
            10'(touch_ctrl_pkg::IDX_SEQ_CTRL):
                rd_word = irq_and_sequence_control;
            10'(touch_ctrl_pkg::IDX_IRQ_STATUS):
                rd_word = {13'h0000, irq_status};
            10'(touch_ctrl_pkg::IDX_IRQ_MASK): rd_word = {13'h0000, irq_mask};
            10'(touch_ctrl_pkg::IDX_STATE):
                rd_word = {8'h00, busy, touch_sync, 3'h0, cur};
            default: rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= rd_en;
            pslverr <= rd_en && !mapped;
            if (rd_en && !pwrite)
                prdata <= {16'h0000, rd_word};
        end
    end

    // Control registers; a host write to the mode bits beats a revert
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conv_ctrl <= touch_ctrl_pkg::CONV_CTRL_RST;
            power_filter_delay_control <= touch_ctrl_pkg::PWR_CTRL_RST;
            irq_and_sequence_control <= touch_ctrl_pkg::SEQ_CTRL_RST;
            irq_mask <= 3'h0;
        end
        else
        begin
            if (revert_mode)
                conv_ctrl[touch_ctrl_pkg::MODE_LSB +: 2] <=
                    touch_ctrl_pkg::MODE_OFF;
            if (wr_en)
            begin
                case (idx)
                    10'(touch_ctrl_pkg::IDX_CONV_CTRL):
                        conv_ctrl <= pwdata[15:0];
                    10'(touch_ctrl_pkg::IDX_PWR_CTRL):
                        power_filter_delay_control <= pwdata[15:0];
                    10'(touch_ctrl_pkg::IDX_SEQ_CTRL):
                        irq_and_sequence_control <= {pwdata[15:1], 1'b0};
                    10'(touch_ctrl_pkg::IDX_IRQ_MASK):
                        irq_mask <= pwdata[2:0];
                    default: ;
                endcase
            end
        end
    end

    // Sticky events; a new event wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_en && (idx == 10'(touch_ctrl_pkg::IDX_IRQ_STATUS)))
                irq_status <= (irq_status & ~pwdata[2:0]) | events;
            else
                irq_status <= irq_status | events;
            irq <= |(irq_status & irq_mask);
        end
    end

    conv_delay_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_delay (
        .pclk(pclk),
        .presetn(presetn),
        .start(dly_go),
        .code(power_filter_delay_control[touch_ctrl_pkg::FCD_LSB +: 4]),
        .done(dly_done)
    );

    // Conversion sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= S_IDLE;
            cur <= 3'h0;
            dly_go <= 1'b0;
            revert_mode <= 1'b0;
            events <= 3'h0;
            conv_start <= 1'b0;
        end
        else
        begin
            dly_go <= 1'b0;
            revert_mode <= 1'b0;
            events <= 3'h0;
            conv_start <= 1'b0;
            events[touch_ctrl_pkg::EV_TOUCH] <= touch_sync && !touch_prev;
            if (power_mgmt_field == touch_ctrl_pkg::PM_SHUTDOWN)
                state <= S_IDLE;
            else
            begin
                case (state)
                    S_IDLE:
                    begin
                        // Old mode bits still stand while a revert lands
                        if (revert_mode)
                            state <= S_IDLE;
                        else if (mode == touch_ctrl_pkg::MODE_SINGLE)
                        begin
                            if (channel_select == touch_ctrl_pkg::CH_INVALID)
                            begin
                                events[touch_ctrl_pkg::EV_BAD_CHAN] <= 1'b1;
                                revert_mode <= 1'b1;
                            end
                            else
                            begin
                                cur <= channel_select;
                                dly_go <= 1'b1;
                                state <= S_DELAY;
                            end
                        end
                        else if (mode == touch_ctrl_pkg::MODE_SEQ_SLAVE)
                        begin
                            if (first_ch == 3'h0)
                                revert_mode <= 1'b1;
                            else
                            begin
                                cur <= first_ch;
                                dly_go <= 1'b1;
                                state <= S_DELAY;
                            end
                        end
                        else if (mode == touch_ctrl_pkg::MODE_SEQ_MASTER)
                            state <= S_ARM;
                    end
                    S_ARM:
                    begin
                        if (mode != touch_ctrl_pkg::MODE_SEQ_MASTER)
                            state <= S_IDLE;
                        else if (touch_sync && !touch_prev &&
                                 (first_ch != 3'h0))
                        begin
                            cur <= first_ch;
                            dly_go <= 1'b1;
                            state <= S_DELAY;
                        end
                    end
                    S_DELAY:
                    begin
                        if (dly_done)
                            state <= S_LAUNCH;
                    end
                    S_LAUNCH:
                    begin
                        conv_start <= 1'b1;
                        state <= S_CONV;
                    end
                    S_CONV:
                    begin
                        if (conv_done)
                        begin
                            if (mode == touch_ctrl_pkg::MODE_SINGLE ||
                                next_ch == 3'h0)
                            begin
                                dly_go <= 1'b1;
                                state <= S_POST;
                            end
                            else
                            begin
                                cur <= next_ch;
                                dly_go <= needs_delay(next_ch);
                                state <= needs_delay(next_ch) ?
                                    S_DELAY : S_LAUNCH;
                            end
                        end
                    end
                    S_POST:
                    begin
                        if (dly_done)
                        begin
                            events[touch_ctrl_pkg::EV_SEQ_DONE] <= 1'b1;
                            revert_mode <=
                                (mode != touch_ctrl_pkg::MODE_SEQ_MASTER);
                            state <= S_IDLE;
                        end
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end

    // Channel, method and panel switches, set when a conversion launches
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conv_channel <= 3'h0;
            conv_single_ended <= 1'b0;
            {xp_on, xn_on, yp_on, yn_on} <= 4'h0;
        end
        else if (state == S_LAUNCH)
        begin
            conv_channel <= cur;
            conv_single_ended <= single_ended_select;
            case (cur)
                touch_ctrl_pkg::CH_Y_POS: {xp_on, xn_on, yp_on, yn_on} <= 4'h3;
                touch_ctrl_pkg::CH_X_POS: {xp_on, xn_on, yp_on, yn_on} <= 4'hc;
                touch_ctrl_pkg::CH_PRESS1, touch_ctrl_pkg::CH_PRESS2:
                    {xp_on, xn_on, yp_on, yn_on} <=
                        single_ended_select ? 4'h0 : 4'h6;
                default: {xp_on, xn_on, yp_on, yn_on} <= 4'h0;
            endcase
        end
        else if (!busy)
            {xp_on, xn_on, yp_on, yn_on} <= 4'h0;
    end

    // Power enables; under codes 01 and 11, ADC and temp sensor off while idle, oscillator and bias off when idle in master mode only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {adc_pwr, osc_pwr, bias_pwr, temp_pwr} <= 4'h0;
        end
        else
        begin
            case (power_mgmt_field)
                touch_ctrl_pkg::PM_SHUTDOWN:
                    {adc_pwr, osc_pwr, bias_pwr, temp_pwr} <= 4'h0;
                touch_ctrl_pkg::PM_ALWAYS_ON:
                begin
                    {adc_pwr, osc_pwr, bias_pwr} <= 3'h7;
                    temp_pwr <= busy && (cur == touch_ctrl_pkg::CH_TEMP);
                end
                default:
                begin
                    adc_pwr <= busy;
                    temp_pwr <= busy && (cur == touch_ctrl_pkg::CH_TEMP);
                    osc_pwr <= busy ||
                        (mode != touch_ctrl_pkg::MODE_SEQ_MASTER);
                    bias_pwr <= busy ||
                        (mode != touch_ctrl_pkg::MODE_SEQ_MASTER);
                end
            endcase
        end
    end

    // Shared pin; touch release during conversion waits for idle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pen_touch_irq_n <= 1'b1;
        else if (conv_ctrl[touch_ctrl_pkg::PEN_DIS_BIT])
            pen_touch_irq_n <= !limit_viol;
        else if (!busy || touch_sync)
            pen_touch_irq_n <= !touch_sync;
    end

    AST_SHUTDOWN: assert property (power_mgmt_field == 2'h0 |=>
        !adc_pwr && !osc_pwr && !bias_pwr && !temp_pwr && state == S_IDLE)
        else $error("Shutdown left a block powered");
    AST_ALWAYS_ON: assert property (power_mgmt_field == 2'h2 |=>
        adc_pwr && osc_pwr && bias_pwr)
        else $error("Always-on power code not honoured");
    AST_SINGLE_CHAN: assert property (conv_start && mode == 2'h1 |->
        conv_channel == channel_select)
        else $error("Single conversion on wrong channel");
    AST_SEQ_SELECTED: assert property (conv_start && mode[1] |->
        irq_and_sequence_control[conv_channel])
        else $error("Sequence converted an unselected channel");
    AST_NO_INVALID: assert property (conv_start |->
        conv_channel != 3'h0)
        else $error("Invalid channel code converted");
    AST_METHOD: assert property (conv_start |->
        conv_single_ended == $past(single_ended_select))
        else $error("Measurement method does not follow select bit");
    AST_PRESSURE_SW: assert property (conv_start &&
        !conv_single_ended && conv_channel[2:1] == 2'h2 |->
        xn_on && yp_on && !xp_on && !yn_on)
        else $error("Pressure switch pattern wrong");
    AST_ORDER: assert property (state == S_CONV && conv_done &&
        next_ch != 3'h0 && mode[1] |=> cur < $past(cur))
        else $error("Sequence order not high to low");
    AST_PEN_LIMIT: assert property (conv_ctrl[15] && limit_viol |=>
        !pen_touch_irq_n)
        else $error("Limit alert not shown on shared pin");
    AST_POSITION_DELAY: assert property (state == S_CONV &&
        conv_done && next_ch[2:1] == 2'h3 && mode[1] |=> state == S_DELAY)
        else $error("No settling delay before position channel");
endmodule
`default_nettype wire
